// ==== pic_port_ctrl.sv ====
// Port integration logic: ports K, T, S, AD0 and interrupt pin control
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Edge select set: only falling irq edges count; pending until reset or service.
// - Edge select clear: a low irq pin level is the request.
// - Edge select writes once after reset in normal mode; anytime in special mode.
// - Pin connect bit routes irq pin to interrupt logic; writable anytime.
// - Port S input register returns buffered pin state whatever the direction.
// - Direction bit 1 drives the pin as output, 0 leaves it input.
// - Enabled synchronous serial unit forces port S pins 7-4; stored bits untouched.
// - Enabled second async serial unit forces port S pins 3-2; stored bits untouched.
// - Enabled first async serial unit forces port S pins 1-0; stored bits untouched.
// - AD0 pin as general output drives its register bit.
// - AD0 data read gives register bit if output, else buffered pin if converter_digital_input_enable is set, zero if clear.
// - Port S, AD0 direction and AD0 data registers are read/write anytime.
module pic_port_ctrl #(
   parameter int         AD0_W    = 16,
   parameter logic [7:0] ECLK_RST = pic_pkg::RST_ECLK
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic [11:0]         wb_adr_i,
   input  wire logic [31:0]         wb_dat_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic                wb_we_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire logic                special_mode,
   input  wire logic                irq_pin_n,
   input  wire logic                irq_ack,
   output logic                     irq_req,
   output logic                     irq_out,
   output logic [7:0]               eclk_ctl,
   input  wire logic [7:0]          port_k_in,
   output pic_pkg::pic_pad_t        port_k_pad,
   input  wire logic [7:0]          port_t_in,
   output pic_pkg::pic_pad_t        port_t_pad,
   output logic [7:0]               port_t_reduced_drive,
   output logic [7:0]               port_t_pull_enable,
   output logic [7:0]               port_t_pull_polarity,
   input  wire logic [7:0]          port_s_in,
   output pic_pkg::pic_pad_t        port_s_pad,
   input  wire pic_pkg::pic_force_t sync_serial_unit,
   input  wire pic_pkg::pic_force_t second_async_serial_unit,
   input  wire pic_pkg::pic_force_t first_async_serial_unit,
   input  wire logic [AD0_W-1:0]    port_ad0_in,
   input  wire logic [AD0_W-1:0]    converter_digital_input_enable,
   output logic [AD0_W-1:0]         port_ad0_dout,
   output logic [AD0_W-1:0]         port_ad0_oe
);

   localparam int SW = pic_pkg::SYNC_W - 16 + AD0_W;

   function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
      hit = (adr[11:2] == idx);
   endfunction

   // Bus state
   logic        ack_reg;
   logic [7:0]  rdata_reg;

   // Software registers
   logic [7:0]  eclk_reg;
   logic        edge_sel_reg;
   logic        conn_reg;
   logic        edge_lock_reg;
   logic [7:0]  k_data_reg;
   logic [7:0]  k_dir_reg;
   logic [7:0]  t_data_reg;
   logic [7:0]  t_dir_reg;
   logic [7:0]  t_rdrive_reg;
   logic [7:0]  t_pull_en_reg;
   logic [7:0]  t_pull_pol_reg;
   logic [7:0]  s_data_reg;
   logic [7:0]  s_dir_reg;
   logic [15:0] ad0_data_reg;
   logic [15:0] ad0_dir_reg;
   logic [pic_pkg::ST_W-1:0] stat_reg;
   logic [pic_pkg::ST_W-1:0] irq_en_reg;

   // Input synchroniser and irq state
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic        pin_prev_reg;
   logic        pend_reg;
   logic        req_reg;
   logic        irq_out_reg;

   // Pad drive flops
   pic_pkg::pic_pad_t k_pad_reg;
   pic_pkg::pic_pad_t t_pad_reg;
   pic_pkg::pic_pad_t s_pad_reg;
   logic [AD0_W-1:0]  ad0_dout_reg;
   logic [AD0_W-1:0]  ad0_oe_reg;

   // Bus decode
   wire         req_on  = wb_cyc_i & wb_stb_i;
   wire         ack_next = req_on & ~ack_reg;
   wire         wr      = req_on & wb_we_i & ack_reg & wb_sel_i[0];
   wire [7:0]   wd      = wb_dat_i[7:0];
   wire         wr_eclk = wr & hit(wb_adr_i, pic_pkg::IDX_ECLK_CTL);
   wire         wr_irqc = wr & hit(wb_adr_i, pic_pkg::IDX_IRQ_CTL);
   wire         wr_kd   = wr & hit(wb_adr_i, pic_pkg::IDX_K_DATA);
   wire         wr_kdir = wr & hit(wb_adr_i, pic_pkg::IDX_K_DIR);
   wire         wr_td   = wr & hit(wb_adr_i, pic_pkg::IDX_T_DATA);
   wire         wr_tdir = wr & hit(wb_adr_i, pic_pkg::IDX_T_DIR);
   wire         wr_trd  = wr & hit(wb_adr_i, pic_pkg::IDX_T_RDRIVE);
   wire         wr_tpe  = wr & hit(wb_adr_i, pic_pkg::IDX_T_PULL_EN);
   wire         wr_tpp  = wr & hit(wb_adr_i, pic_pkg::IDX_T_PULL_POL);
   wire         wr_sd   = wr & hit(wb_adr_i, pic_pkg::IDX_S_DATA);
   wire         wr_sdir = wr & hit(wb_adr_i, pic_pkg::IDX_S_DIR);
   wire         wr_adl  = wr & hit(wb_adr_i, pic_pkg::IDX_AD0_LDATA);
   wire         wr_adh  = wr & hit(wb_adr_i, pic_pkg::IDX_AD0_HDATA);
   wire         wr_adld = wr & hit(wb_adr_i, pic_pkg::IDX_AD0_LDIR);
   wire         wr_adhd = wr & hit(wb_adr_i, pic_pkg::IDX_AD0_HDIR);
   wire         wr_clr  = wr & hit(wb_adr_i, pic_pkg::IDX_IRQ_CLR);
   wire         wr_ien  = wr & hit(wb_adr_i, pic_pkg::IDX_IRQ_EN);

   // Synchronised pins
   wire             pin_s = sync2_reg[SW-1];
   wire [7:0]       t_s   = sync2_reg[SW-10 -: 8];
   wire [7:0]       s_s   = sync2_reg[SW-18 -: 8];
   wire [AD0_W-1:0] ad_s  = sync2_reg[AD0_W-1:0];

   // Edge select write: open in special mode, else only before lock
   wire edge_wr_ok  = wr_irqc & (special_mode | ~edge_lock_reg);
   wire edge_wr_bad = wr_irqc & ~special_mode & edge_lock_reg;
   wire fall        = pin_prev_reg & ~pin_s;
   wire req_next    = conn_reg & (edge_sel_reg ? pend_reg : ~pin_s);
   wire pend_next   = (edge_sel_reg & fall) | (pend_reg & ~irq_ack);

   // Status: a new event beats a simultaneous clear
   wire [pic_pkg::ST_W-1:0] st_evt;
   assign st_evt[pic_pkg::ST_REQ_BIT]  = req_next & ~req_reg;
   assign st_evt[pic_pkg::ST_LOCK_BIT] = edge_wr_bad;
   wire [pic_pkg::ST_W-1:0] st_clr  = wr_clr ? wd[pic_pkg::ST_W-1:0] : '0;
   wire [pic_pkg::ST_W-1:0] st_next = st_evt | (stat_reg & ~st_clr);
   // Output built from next values so it stays registered without a cycle of lag
   wire [pic_pkg::ST_W-1:0] irq_en_next = wr_ien ? wd[pic_pkg::ST_W-1:0] : irq_en_reg;

   // Serial units override direction and data; stored bits stay put
   wire [7:0] s_dir_eff;
   wire [7:0] s_out_eff;
   assign s_dir_eff[7:4] = sync_serial_unit.en ? sync_serial_unit.dir : s_dir_reg[7:4];
   assign s_out_eff[7:4] = sync_serial_unit.en ? sync_serial_unit.dout : s_data_reg[7:4];
   assign s_dir_eff[3:2] = second_async_serial_unit.en ? second_async_serial_unit.dir[1:0]
                                                        : s_dir_reg[3:2];
   assign s_out_eff[3:2] = second_async_serial_unit.en ? second_async_serial_unit.dout[1:0]
                                                        : s_data_reg[3:2];
   assign s_dir_eff[1:0] = first_async_serial_unit.en ? first_async_serial_unit.dir[1:0]
                                                       : s_dir_reg[1:0];
   assign s_out_eff[1:0] = first_async_serial_unit.en ? first_async_serial_unit.dout[1:0]
                                                       : s_data_reg[1:0];

   // AD0 readback; digital input path only when the converter allows it
   wire [AD0_W-1:0] ad_data_w = ad0_data_reg[AD0_W-1:0];
   wire [AD0_W-1:0] ad_dir_w  = ad0_dir_reg[AD0_W-1:0];
   wire [AD0_W-1:0] ad_in_ok  = ad_s & converter_digital_input_enable;
   wire [AD0_W-1:0] ad_rd     = (ad_dir_w & ad_data_w) | (~ad_dir_w & ad_in_ok);
   wire [15:0]      ad_rd16   = 16'(ad_rd);

   wire [7:0] irqc_rd = {edge_sel_reg, conn_reg, 6'h00};

   // Read selection; unmapped indexes read zero
   wire [7:0] rd_next =
        ({8{hit(wb_adr_i, pic_pkg::IDX_ECLK_CTL)}}   & eclk_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_IRQ_CTL)}}    & irqc_rd)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_K_DATA)}}     & k_data_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_K_DIR)}}      & k_dir_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_DATA)}}     & t_data_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_INPUT)}}    & t_s)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_DIR)}}      & t_dir_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_RDRIVE)}}   & t_rdrive_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_PULL_EN)}}  & t_pull_en_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_T_PULL_POL)}} & t_pull_pol_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_S_DATA)}}     & s_data_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_S_INPUT)}}    & s_s)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_S_DIR)}}      & s_dir_reg)
      | ({8{hit(wb_adr_i, pic_pkg::IDX_AD0_LDATA)}}  & ad_rd16[7:0])
      | ({8{hit(wb_adr_i, pic_pkg::IDX_AD0_HDATA)}}  & ad_rd16[15:8])
      | ({8{hit(wb_adr_i, pic_pkg::IDX_AD0_LDIR)}}   & ad0_dir_reg[7:0])
      | ({8{hit(wb_adr_i, pic_pkg::IDX_AD0_HDIR)}}   & ad0_dir_reg[15:8])
      | ({8{hit(wb_adr_i, pic_pkg::IDX_IRQ_STAT)}}   & 8'(stat_reg))
      | ({8{hit(wb_adr_i, pic_pkg::IDX_IRQ_EN)}}     & 8'(irq_en_reg));

   // Wishbone slave: ack one cycle after the request, data loaded with it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg   <= 1'b0;
         rdata_reg <= pic_pkg::RST_BYTE;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= ack_next ? rd_next : pic_pkg::RST_BYTE;
      end
   end

   // Two-flop synchroniser; stage one feeds stage two only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= {irq_pin_n, port_k_in, port_t_in, port_s_in, port_ad0_in};
         sync2_reg <= sync1_reg;
      end
   end

   // Interrupt pin control and request generation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         edge_sel_reg  <= 1'b0;
         conn_reg      <= 1'b0;
         edge_lock_reg <= 1'b0;
         pin_prev_reg  <= 1'b1;
         pend_reg      <= 1'b0;
         req_reg       <= 1'b0;
      end else begin
         if (edge_wr_ok) begin
            edge_sel_reg <= wd[pic_pkg::IRQ_EDGE_BIT];
         end
         if (wr_irqc) begin
            conn_reg <= wd[pic_pkg::IRQ_CONN_BIT];
         end
         if (wr_irqc & ~special_mode) begin
            edge_lock_reg <= 1'b1;
         end
         pin_prev_reg <= pin_s;
         pend_reg     <= pend_next;
         req_reg      <= req_next;
      end
   end

   // Block interrupt: sticky status, enable mask, level output
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg    <= '0;
         irq_en_reg  <= '0;
         irq_out_reg <= 1'b0;
      end else begin
         stat_reg    <= st_next;
         irq_en_reg  <= irq_en_next;
         irq_out_reg <= |(st_next & irq_en_next);
      end
   end

   // Clock output control and ports K, T
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eclk_reg       <= ECLK_RST;
         k_data_reg     <= pic_pkg::RST_BYTE;
         k_dir_reg      <= pic_pkg::RST_BYTE;
         t_data_reg     <= pic_pkg::RST_BYTE;
         t_dir_reg      <= pic_pkg::RST_BYTE;
         t_rdrive_reg   <= pic_pkg::RST_BYTE;
         t_pull_en_reg  <= pic_pkg::RST_BYTE;
         t_pull_pol_reg <= pic_pkg::RST_BYTE;
      end else begin
         if (wr_eclk) begin
            eclk_reg <= wd;
         end
         if (wr_kd) begin
            k_data_reg <= wd & pic_pkg::K_MASK;
         end
         if (wr_kdir) begin
            k_dir_reg <= wd & pic_pkg::K_MASK;
         end
         if (wr_td) begin
            t_data_reg <= wd;
         end
         if (wr_tdir) begin
            t_dir_reg <= wd;
         end
         if (wr_trd) begin
            t_rdrive_reg <= wd;
         end
         if (wr_tpe) begin
            t_pull_en_reg <= wd;
         end
         if (wr_tpp) begin
            t_pull_pol_reg <= wd;
         end
      end
   end

   // Port S and AD0 registers, writable at any time
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_data_reg   <= pic_pkg::RST_BYTE;
         s_dir_reg    <= pic_pkg::RST_BYTE;
         ad0_data_reg <= '0;
         ad0_dir_reg  <= '0;
      end else begin
         if (wr_sd) begin
            s_data_reg <= wd;
         end
         if (wr_sdir) begin
            s_dir_reg <= wd;
         end
         if (wr_adl) begin
            ad0_data_reg[7:0] <= wd;
         end
         if (wr_adh) begin
            ad0_data_reg[15:8] <= wd;
         end
         if (wr_adld) begin
            ad0_dir_reg[7:0] <= wd;
         end
         if (wr_adhd) begin
            ad0_dir_reg[15:8] <= wd;
         end
      end
   end

   // Pad drive is registered, so pins follow the registers one cycle late
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         k_pad_reg    <= '0;
         t_pad_reg    <= '0;
         s_pad_reg    <= '0;
         ad0_dout_reg <= '0;
         ad0_oe_reg   <= '0;
      end else begin
         k_pad_reg    <= '{dout: k_data_reg, oe: k_dir_reg};
         t_pad_reg    <= '{dout: t_data_reg, oe: t_dir_reg};
         s_pad_reg    <= '{dout: s_out_eff, oe: s_dir_eff};
         ad0_dout_reg <= ad_data_w;
         ad0_oe_reg   <= ad_dir_w;
      end
   end

   assign wb_ack_o             = ack_reg;
   assign wb_dat_o             = {24'h000000, rdata_reg};
   assign irq_req              = req_reg;
   assign irq_out              = irq_out_reg;
   assign eclk_ctl             = eclk_reg;
   assign port_k_pad           = k_pad_reg;
   assign port_t_pad           = t_pad_reg;
   assign port_s_pad           = s_pad_reg;
   assign port_t_reduced_drive = t_rdrive_reg;
   assign port_t_pull_enable   = t_pull_en_reg;
   assign port_t_pull_polarity = t_pull_pol_reg;
   assign port_ad0_dout        = ad0_dout_reg;
   assign port_ad0_oe          = ad0_oe_reg;

endmodule

// ==== pic_pkg.sv ====
// Shared constants and carrier types of the port integration and IRQ block
package pic_pkg;

   // Register indexes; byte address on the bus is four times the index
   localparam logic [9:0] IDX_ECLK_CTL   = 10'h01c;
   localparam logic [9:0] IDX_IRQ_CTL    = 10'h01e;
   localparam logic [9:0] IDX_K_DATA     = 10'h032;
   localparam logic [9:0] IDX_K_DIR      = 10'h033;
   localparam logic [9:0] IDX_T_DATA     = 10'h240;
   localparam logic [9:0] IDX_T_INPUT    = 10'h241;
   localparam logic [9:0] IDX_T_DIR      = 10'h242;
   localparam logic [9:0] IDX_T_RDRIVE   = 10'h243;
   localparam logic [9:0] IDX_T_PULL_EN  = 10'h244;
   localparam logic [9:0] IDX_T_PULL_POL = 10'h245;
   localparam logic [9:0] IDX_S_DIR      = 10'h249;
   localparam logic [9:0] IDX_AD0_LDATA  = 10'h271;
   localparam logic [9:0] IDX_S_DATA     = 10'h250;
   localparam logic [9:0] IDX_S_INPUT    = 10'h251;
   localparam logic [9:0] IDX_AD0_HDIR   = 10'h272;
   localparam logic [9:0] IDX_AD0_LDIR   = 10'h273;
   localparam logic [9:0] IDX_AD0_HDATA  = 10'h274;
   localparam logic [9:0] IDX_IRQ_STAT   = 10'h280;
   localparam logic [9:0] IDX_IRQ_CLR    = 10'h281;
   localparam logic [9:0] IDX_IRQ_EN     = 10'h282;

   // Interrupt pin control fields
   localparam int IRQ_EDGE_BIT = 7;
   localparam int IRQ_CONN_BIT = 6;

   // Implemented bits of port K (bit 6 absent)
   localparam logic [7:0] K_MASK = 8'hbf;

   // Status bits of the block interrupt
   localparam int ST_REQ_BIT  = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_W        = 2;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_ECLK = 8'h00;

   // Width of the synchronised input bundle: irq, K, T, S, AD0
   localparam int SYNC_W = 41;

   // Pin drive of one 8-bit port
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
   } pic_pad_t;

   // Direction and data override from a serial peripheral
   typedef struct packed {
      logic       en;
      logic [3:0] dir;
      logic [3:0] dout;
   } pic_force_t;

endpackage

// ==== pic_port_ctrl_sva.sv ====
// Concurrent checks on the register bus and the interrupt pin path
`timescale 1ns/1ps
module pic_port_ctrl_sva (
   input logic        mclk,
   input logic        rst_n,
   input logic [11:0] wb_adr_i,
   input logic [31:0] wb_dat_i,
   input logic [3:0]  wb_sel_i,
   input logic        wb_we_i,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        special_mode,
   input logic        irq_pin_n,
   input logic        irq_ack,
   input logic        irq_req
);
   logic edge_reg;
   logic conn_reg;
   logic lock_reg;
   wire  ctl_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_adr_i[11:2] == pic_pkg::IDX_IRQ_CTL;
   wire  ctl_wr  = ctl_hit && wb_we_i && wb_sel_i[0];
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Shadow of the control bits; any normal-mode write locks edge select
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {edge_reg, conn_reg, lock_reg} <= 3'h0;
      end else if (ctl_wr) begin
         conn_reg <= wb_dat_i[pic_pkg::IRQ_CONN_BIT];
         edge_reg <= (special_mode || !lock_reg) ? wb_dat_i[pic_pkg::IRQ_EDGE_BIT] : edge_reg;
         lock_reg <= lock_reg || !special_mode;
      end
   end
   AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered after one cycle");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   AST_CTL_READ: assert property (ctl_hit && !wb_we_i |-> wb_dat_o[7:0] == {edge_reg, conn_reg, 6'h00})
      else $error("pin control readback wrong");
   AST_LEVEL: assert property ((!edge_reg && conn_reg && !irq_pin_n) [*3] |=> irq_req)
      else $error("low level not requested");
   AST_EDGE_SET: assert property ((edge_reg && conn_reg && $fell(irq_pin_n)) ##1
      (edge_reg && conn_reg && !irq_ack) [*3] |-> ##[0:1] irq_req)
      else $error("falling edge not requested");
   AST_EDGE_HOLD: assert property ((irq_req && edge_reg && conn_reg && !irq_ack) [*2] |=> irq_req)
      else $error("pending edge lost without service");
   AST_EDGE_ONLY: assert property ((edge_reg && conn_reg && irq_pin_n && !irq_req) [*4] |=> !irq_req)
      else $error("request without falling edge");
   AST_DISCONNECT: assert property (!conn_reg [*2] |-> !irq_req)
      else $error("request while pin disconnected");
endmodule
bind pic_port_ctrl pic_port_ctrl_sva u_sva (.mclk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
   .wb_stb_i, .wb_dat_o, .wb_ack_o, .special_mode, .irq_pin_n, .irq_ack, .irq_req);

// ==== pic_pin_model.sv ====
// Package pins with external drivers, a short to ground and the irq pull-up
`timescale 1ns/1ps
module pic_pin_model (
   input  pic_pkg::pic_pad_t port_k_pad,
   input  pic_pkg::pic_pad_t port_t_pad,
   input  pic_pkg::pic_pad_t port_s_pad,
   input  logic [15:0]       port_ad0_dout,
   input  logic [15:0]       port_ad0_oe,
   input  logic [7:0]        ext8,
   input  logic [15:0]       ext16,
   input  logic [7:0]        s_short,
   input  logic              irq_low,
   output logic [7:0]        port_k_in,
   output logic [7:0]        port_t_in,
   output logic [7:0]        port_s_in,
   output logic [15:0]       port_ad0_in,
   output logic              irq_pin_n
);
   // Driven pins show the pad, released pins the external level
   assign port_k_in   = port_k_pad.oe & port_k_pad.dout | ~port_k_pad.oe & ext8;
   assign port_t_in   = port_t_pad.oe & port_t_pad.dout | ~port_t_pad.oe & ext8;
   // A short to ground overpowers the pad driver
   assign port_s_in   = (port_s_pad.oe & port_s_pad.dout | ~port_s_pad.oe & ext8) & ~s_short;
   assign port_ad0_in = port_ad0_oe & port_ad0_dout | ~port_ad0_oe & ext16;
   // Pulled up; only the external source pulls it low
   assign irq_pin_n   = ~irq_low;
endmodule

// ==== pic_port_ctrl_tb_top.sv ====
// Self-checking bench for the port integration and irq control block
`timescale 1ns/1ps
module pic_port_ctrl_tb_top;
   logic                mclk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, special_mode, irq_ack, irq_low;
   logic [11:0]         wb_adr_i;
   logic [31:0]         wb_dat_i, wb_dat_o;
   logic [3:0]          wb_sel_i;
   logic                wb_ack_o, irq_req, irq_out, irq_pin_n;
   logic [7:0]          eclk_ctl, port_k_in, port_t_in, port_s_in, ext8, s_short;
   logic [7:0]          port_t_reduced_drive, port_t_pull_enable, port_t_pull_polarity;
   pic_pkg::pic_pad_t   port_k_pad, port_t_pad, port_s_pad;
   pic_pkg::pic_force_t sync_serial_unit, second_async_serial_unit, first_async_serial_unit;
   logic [15:0]         port_ad0_in, converter_digital_input_enable, port_ad0_dout, port_ad0_oe, ext16;
   int                  failures, total_checks;

   pic_port_ctrl dut (.mclk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
      .wb_ack_o, .special_mode, .irq_pin_n, .irq_ack, .irq_req, .irq_out, .eclk_ctl, .port_k_in, .port_k_pad,
      .port_t_in, .port_t_pad, .port_t_reduced_drive, .port_t_pull_enable, .port_t_pull_polarity, .port_s_in,
      .port_s_pad, .sync_serial_unit, .second_async_serial_unit, .first_async_serial_unit, .port_ad0_in,
      .converter_digital_input_enable, .port_ad0_dout, .port_ad0_oe);
   pic_pin_model u_pins (.port_k_pad, .port_t_pad, .port_s_pad, .port_ad0_dout, .port_ad0_oe, .ext8, .ext16,
      .s_short, .irq_low, .port_k_in, .port_t_in, .port_s_in, .port_ad0_in, .irq_pin_n);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One classic cycle; a read compares its data with d
   task automatic acc(input logic [9:0] idx, input logic we, input logic [7:0] d);
      int n;
      n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, idx, 2'h0, 24'h0, d, 4'hf};
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (!we || n >= 20) check(n < 20 ? wb_dat_o : 32'hffff_ffff, {24'h0, d});
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge mclk);
   endtask
   task automatic t_regs();
      logic [9:0] idx [8] = '{pic_pkg::IDX_ECLK_CTL, pic_pkg::IDX_K_DATA, pic_pkg::IDX_K_DIR, pic_pkg::IDX_T_DATA,
         pic_pkg::IDX_T_DIR, pic_pkg::IDX_T_RDRIVE, pic_pkg::IDX_T_PULL_EN, pic_pkg::IDX_T_PULL_POL};
      foreach (idx[i]) begin
         acc(idx[i], 1'b0, pic_pkg::RST_BYTE);
         acc(idx[i], 1'b1, 8'hff);
         acc(idx[i], 1'b0, (i == 1 || i == 2) ? pic_pkg::K_MASK : 8'hff);
      end
      check({eclk_ctl, port_t_reduced_drive, port_t_pull_enable, port_t_pull_polarity}, 32'hffff_ffff);
      check({port_k_pad, port_t_pad}, {pic_pkg::K_MASK, pic_pkg::K_MASK, 16'hffff});
      acc(pic_pkg::IDX_T_INPUT, 1'b0, 8'hff);
      acc(10'h3ff, 1'b1, 8'h5a);
      acc(10'h3ff, 1'b0, 8'h00);
   endtask
   task automatic t_port_s();
      ext8 <= 8'h0f;
      s_short <= 8'h04;
      acc(pic_pkg::IDX_S_DIR, 1'b1, 8'ha5);
      acc(pic_pkg::IDX_S_DATA, 1'b1, 8'h3c);
      cyc(3);
      check(port_s_pad, 16'h3ca5);
      acc(pic_pkg::IDX_S_INPUT, 1'b0, 8'h2a);
      {sync_serial_unit, second_async_serial_unit, first_async_serial_unit} <= {9'h13a, 9'h113, 9'h121};
      cyc(4);
      check(port_s_pad, 16'had36);
      acc(pic_pkg::IDX_S_DIR, 1'b0, 8'ha5);
      acc(pic_pkg::IDX_S_INPUT, 1'b0, 8'h29);
      {sync_serial_unit, second_async_serial_unit, first_async_serial_unit} <= 27'h0;
      cyc(2);
      check(port_s_pad, 16'h3ca5);
   endtask
   task automatic t_ad0();
      ext16 <= 16'h00a0;
      converter_digital_input_enable <= 16'h00ff;
      acc(pic_pkg::IDX_AD0_LDIR, 1'b1, 8'h0f);
      acc(pic_pkg::IDX_AD0_LDATA, 1'b1, 8'h55);
      cyc(3);
      check({port_ad0_oe, port_ad0_dout & port_ad0_oe}, 32'h000f_0005);
      acc(pic_pkg::IDX_AD0_LDATA, 1'b0, 8'ha5);
      converter_digital_input_enable <= 16'h0000;
      cyc(3);
      acc(pic_pkg::IDX_AD0_LDATA, 1'b0, 8'h05);
      acc(pic_pkg::IDX_AD0_HDIR, 1'b1, 8'h81);
      acc(pic_pkg::IDX_AD0_HDIR, 1'b0, 8'h81);
   endtask
   task automatic t_irq();
      acc(pic_pkg::IDX_IRQ_EN, 1'b1, 8'h03);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b1, 8'h40);
      irq_low <= 1'b1;
      cyc(5);
      check({irq_req, irq_out}, 2'b11);
      irq_low <= 1'b0;
      cyc(5);
      check(irq_req, 1'b0);
      acc(pic_pkg::IDX_IRQ_CLR, 1'b1, 8'h01);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b1, 8'hff);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b0, 8'h40);
      acc(pic_pkg::IDX_IRQ_STAT, 1'b0, 8'h02);
      check(irq_out, 1'b1);
      acc(pic_pkg::IDX_IRQ_EN, 1'b1, 8'h00);
      acc(pic_pkg::IDX_IRQ_CLR, 1'b0, 8'h00);
      check(irq_out, 1'b0);
      special_mode <= 1'b1;
      acc(pic_pkg::IDX_IRQ_CLR, 1'b1, 8'h03);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b1, 8'hc0);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b0, 8'hc0);
      irq_low <= 1'b1;
      cyc(6);
      irq_low <= 1'b0;
      cyc(6);
      check(irq_req, 1'b1);
      irq_ack <= 1'b1;
      cyc(1);
      irq_ack <= 1'b0;
      cyc(3);
      check(irq_req, 1'b0);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b1, 8'h80);
      irq_low <= 1'b1;
      cyc(6);
      check(irq_req, 1'b0);
      acc(pic_pkg::IDX_IRQ_CTL, 1'b1, 8'hc0);
      cyc(2);
      check(irq_req, 1'b1);
      acc(pic_pkg::IDX_IRQ_STAT, 1'b0, 8'h01);
      check(irq_out, 1'b0);
   endtask
   task automatic final_report();
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      {rst_n, wb_we_i, wb_cyc_i, wb_stb_i, special_mode, irq_ack, irq_low} = 7'h00;
      {wb_adr_i, wb_dat_i, wb_sel_i, ext8, s_short, ext16} = 80'h0;
      {sync_serial_unit, second_async_serial_unit, first_async_serial_unit} = 27'h0;
      converter_digital_input_enable = 16'h0000;
      failures = 0;
      total_checks = 0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      cyc(2);
      t_regs();
      t_port_s();
      t_ad0();
      t_irq();
      final_report();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      final_report();
   end
endmodule
